// file: iowd_defs.vh
// How it works
// - A write to I/O port 0x443 arms the watchdog with the low four data bits as timeout code.
// - A write to I/O port 0x441 disarms the watchdog and its data is ignored.
// - On expiry the block raises reset or NMI as the jumper input selects.
// - The interval is (15 minus code) times 8 seconds, so F is 0 s and 0 is 120 s.
// - The interval must be within 25 percent of nominal, and within 4 percent for codes F and E.
`ifndef IOWD_DEFS_VH
`define IOWD_DEFS_VH

// ----------------------------------------
// Port addresses and fields
// ----------------------------------------
`define IOWD_ADDR_DISARM 16'h0441
`define IOWD_ADDR_ARM 16'h0443
`define IOWD_CODE_MSB 3
`define IOWD_CODE_MAX 4'hF
`define IOWD_STEP_SEC 32'h0000_0008

// ----------------------------------------
// Timing
// ----------------------------------------
`define IOWD_CLK_HZ 32'h05F5_E100
`define IOWD_PULSE_CYC 32'h0000_0010
`define IOWD_SEC_W 7
`define IOWD_DIV_W 32
`define IOWD_PULSE_W 8

`endif

// file: iowd_watchdog.v
`include "iowd_defs.vh"

module iowd_watchdog #(
  parameter CYC_PER_SEC = `IOWD_CLK_HZ,
  parameter PULSE_CYC = `IOWD_PULSE_CYC
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Host I/O write port
  input wire io_wr_in,
  input wire [15:0] io_addr_in,
  input wire [15:0] io_data_in,
  // Board jumper, high selects NMI, low selects reset
  input wire sel_nmi_in,
  // Expiry actions and armed status
  output wire sys_rst_out,
  output wire nmi_out,
  output wire armed_out
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam DIV_W = `IOWD_DIV_W;
  localparam SEC_W = `IOWD_SEC_W;
  localparam PULSE_W = `IOWD_PULSE_W;
  localparam [DIV_W-1:0] DIV_ZERO = {DIV_W{1'h0}};
  localparam [DIV_W-1:0] DIV_ONE = {{(DIV_W-1){1'h0}}, 1'h1};
  localparam [DIV_W-1:0] DIV_LAST = CYC_PER_SEC - 1;
  localparam [SEC_W-1:0] SEC_ZERO = {SEC_W{1'h0}};
  localparam [SEC_W-1:0] SEC_ONE = {{(SEC_W-1){1'h0}}, 1'h1};
  localparam [PULSE_W-1:0] PULSE_ZERO = {PULSE_W{1'h0}};
  localparam [PULSE_W-1:0] PULSE_ONE = {{(PULSE_W-1){1'h0}}, 1'h1};
  localparam [31:0] PULSE_FULL = PULSE_CYC;
  localparam [PULSE_W-1:0] PULSE_LOAD = PULSE_FULL[PULSE_W-1:0] - PULSE_ONE;

  // ----------------------------------------
  // States
  // ----------------------------------------
  // One-hot: idle waits for an arm write, count runs the interval.
  localparam ST_W = 2;
  localparam [ST_W-1:0] ST_IDLE = 2'h1;
  localparam [ST_W-1:0] ST_COUNT = 2'h2;
  localparam ST_COUNT_BIT = 1;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // code to seconds
  // Whole multiples of the one second tick keep the error far inside the
  // allowed tolerance, with a restart granularity of one clock cycle.
  function [SEC_W-1:0] secs_of;
    input [`IOWD_CODE_MSB:0] code;
    reg [31:0] full;
    begin
      full = `IOWD_STEP_SEC * (`IOWD_CODE_MAX - code);
      secs_of = full[SEC_W-1:0];
    end
  endfunction

  function port_hit;
    input wr;
    input [15:0] addr;
    input [15:0] port;
    begin
      port_hit = wr && (addr == port);
    end
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire arm_wr;
  wire dis_wr;
  assign arm_wr = port_hit(io_wr_in, io_addr_in, `IOWD_ADDR_ARM);
  // disarm port decode
  // Only the write strobe and the address are decoded, so the data of a disarm
  // write is never looked at.
  assign dis_wr = port_hit(io_wr_in, io_addr_in, `IOWD_ADDR_DISARM);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [DIV_W-1:0] div_q;
  reg [DIV_W-1:0] div_d;
  reg tick_q;
  reg tick_d;
  reg [ST_W-1:0] state_q;
  reg [ST_W-1:0] state_d;
  reg [SEC_W-1:0] secs_q;
  reg [SEC_W-1:0] secs_d;
  reg [PULSE_W-1:0] pulse_q;
  reg [PULSE_W-1:0] pulse_d;
  reg rst_act_q;
  reg rst_act_d;
  reg nmi_act_q;
  reg nmi_act_d;
  wire counting;
  wire at_zero;
  wire fire;

  assign counting = state_q[ST_COUNT_BIT];
  assign at_zero = (secs_q == SEC_ZERO);
  // An arm or disarm write in the expiry cycle wins over the expiry itself.
  assign fire = counting && at_zero && !arm_wr && !dis_wr;

  // ----------------------------------------
  // Seconds timebase
  // ----------------------------------------
  // whole second ticks
  // Restarting the divider on every arm write keeps each second whole.
  always @* begin
    div_d = div_q + DIV_ONE;
    tick_d = 1'h0;
    if (arm_wr || (div_q == DIV_LAST)) begin
      div_d = DIV_ZERO;
      tick_d = !arm_wr;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= DIV_ZERO;
      tick_q <= 1'h0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // Arm state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (arm_wr) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (dis_wr) begin
          state_d = ST_IDLE;
        end else if (fire) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  always @* begin
    secs_d = secs_q;
    if (arm_wr) begin
      secs_d = secs_of(io_data_in[`IOWD_CODE_MSB:0]);
    end else if (counting && !dis_wr && !at_zero && tick_q) begin
      secs_d = secs_q - SEC_ONE;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      secs_q <= SEC_ZERO;
    end else begin
      secs_q <= secs_d;
    end
  end

  // ----------------------------------------
  // Expiry action
  // ----------------------------------------
  // jumper picks action
  // The jumper is read in the expiry cycle only, and a disarm does not cut a
  // running pulse, so the board always sees a full reset or NMI.
  always @* begin
    pulse_d = pulse_q;
    rst_act_d = rst_act_q;
    nmi_act_d = nmi_act_q;
    if (pulse_q != PULSE_ZERO) begin
      pulse_d = pulse_q - PULSE_ONE;
    end else begin
      rst_act_d = 1'h0;
      nmi_act_d = 1'h0;
    end
    if (fire) begin
      pulse_d = PULSE_LOAD;
      rst_act_d = !sel_nmi_in;
      nmi_act_d = sel_nmi_in;
    end
  end

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_q <= PULSE_ZERO;
      rst_act_q <= 1'h0;
      nmi_act_q <= 1'h0;
    end else begin
      pulse_q <= pulse_d;
      rst_act_q <= rst_act_d;
      nmi_act_q <= nmi_act_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop, so the board never sees a decode glitch.
  assign sys_rst_out = rst_act_q;
  assign nmi_out = nmi_act_q;
  assign armed_out = state_q[ST_COUNT_BIT];

endmodule

// file: iowd_watchdog_asserts.sv
module iowd_chk (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // Host I/O write port
  input wire io_wr_in,
  input wire [15:0] io_addr_in,
  input wire [15:0] io_data_in,
  // Board jumper
  input wire sel_nmi_in,
  // Watched outputs
  input wire sys_rst_out,
  input wire nmi_out,
  input wire armed_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  wire arm = io_wr_in && io_addr_in == 16'h0443;
  wire dis = io_wr_in && io_addr_in == 16'h0441;
  wire act = sys_rst_out | nmi_out;
  a_arm_sets: assert property (arm |=> armed_out)
    else $error("arm write did not set armed");
  a_disarm_clears: assert property (dis |=> !armed_out)
    else $error("disarm write left armed");
  // The jumper is taken in the expiry cycle, one edge before the rise.
  a_nmi_jumper: assert property (
    $rose(nmi_out) |-> $past(sel_nmi_in)) else $error("nmi against jumper");
  a_rst_jumper: assert property (
    $rose(sys_rst_out) |-> !$past(sel_nmi_in))
    else $error("reset against jumper");
  a_one_action: assert property (!(sys_rst_out && nmi_out))
    else $error("reset and nmi together");
  // An arm or disarm write in the expiry cycle wins, so only a quiet next cycle counts.
  a_zero_time: assert property (
    arm && io_data_in[3:0] == 4'hF ##1 !io_wr_in |-> ##1 act)
    else $error("code f did not fire at once");
  // A pulse already running is not cut, so only a quiet arm counts.
  a_no_early: assert property (arm && !act &&
    io_data_in[3:0] == 4'hE |=> !act [*8]) else $error("early expiry");
endmodule
bind iowd_watchdog iowd_chk u_chk (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .io_wr_in(io_wr_in),
  .io_addr_in(io_addr_in),
  .io_data_in(io_data_in),
  .sel_nmi_in(sel_nmi_in),
  .sys_rst_out(sys_rst_out),
  .nmi_out(nmi_out),
  .armed_out(armed_out)
);

// file: test_io_port_watchdog_timer.sv
module test_io_port_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_in = 1, io_wr_in = 0, sel_nmi_in = 1;
  logic [15:0] io_addr_in = 0, io_data_in = 0;
  wire sys_rst_out, nmi_out, armed_out;
  int fail_count = 0, total_checks = 0, n;
  // Two cycles a second keeps the longest code at 240 cycles.
  iowd_watchdog #(.CYC_PER_SEC(2)) DUT (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .io_wr_in(io_wr_in),
    .io_addr_in(io_addr_in),
    .io_data_in(io_data_in),
    .sel_nmi_in(sel_nmi_in),
    .sys_rst_out(sys_rst_out),
    .nmi_out(nmi_out),
    .armed_out(armed_out)
  );
  initial forever #5 clk_sys_in = ~clk_sys_in;
  task chk(string s, logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("[FAIL] %s exp %0h got %0h", s, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(logic [15:0] a, d);
    @(negedge clk_sys_in);
    {io_wr_in, io_addr_in, io_data_in} = {1'b1, a, d};
    @(negedge clk_sys_in);
    io_wr_in = 0;
  endtask
  task act;
    for (n = 0; !(nmi_out | sys_rst_out); n++) begin
      if (n == 300) begin
        chk("timeout", 0, 1);
        end_sim;
      end
      @(negedge clk_sys_in);
    end
  endtask
  task t_fast;
    wr(16'h0443, 16'hFFFF);
    act;
    chk("nmi", 1, nmi_out);
    chk("delay_f", 1, n);
    repeat (20) @(negedge clk_sys_in);
  endtask
  task t_restart;
    sel_nmi_in = 0;
    wr(16'h0443, 16'h123E);
    repeat (10) @(negedge clk_sys_in);
    wr(16'h0443, 16'hABCE);
    act;
    chk("rst", 1, sys_rst_out);
    chk("restart", 1, n >= 17 && n <= 18);
    repeat (20) @(negedge clk_sys_in);
  endtask
  // Rewriting the arm port every second must hold off an 8 s interval.
  task t_refresh;
    for (int i = 0; i < 12; i++) begin
      wr(16'h0443, 16'h000E);
      chk("refresh", 0, nmi_out | sys_rst_out);
    end
    wr(16'h0441, 16'h0000);
    chk("refresh_off", 0, armed_out);
  endtask
  task t_disarm;
    wr(16'h0443, 16'h0000);
    chk("armed", 1, armed_out);
    wr(16'h0442, 16'h000F);
    chk("other_port", 1, armed_out);
    wr(16'h0441, 16'h000F);
    chk("disarmed", 0, armed_out);
    repeat (260) begin
      @(negedge clk_sys_in);
      chk("quiet", 0, nmi_out | sys_rst_out);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_in);
    rst_in = 0;
    t_fast;
    t_restart;
    t_refresh;
    t_disarm;
    end_sim;
  end
endmodule
